// >>> hdl/sipo_shifter.sv
/*
 Serial-in parallel-out shifter with a storage register and a serial
 output for cascading.

 Contents:
  - edge detection on the shift clock and storage clock pins
  - an eight-stage shift chain with a level-sensitive shift clear
  - a storage register, in a module of its own, with its own clear
  - the serial output, taken from the last shift stage
  - the parallel outputs, taken straight from the storage register

 Pin use:
  - serial_in: level entered into stage 0 at a shift edge
  - shift_clock: a rising level moves the chain by one stage
  - storage_clock: a rising level copies the chain into storage
  - shift_clear_n: low holds the chain and serial_out at zero
  - storage_clear_n: low holds storage and parallel_out at zero
  - parallel_out: bit n shows stored stage n
  - serial_out: shows the last shift stage

 Behaviour as seen from the pins:
  - a clock pin edge is a low sample followed by a high sample
  - chain and storage change at the sys_clk edge that sees the high sample
  - outputs show the new value from the following cycle on
  - a clear acts at the next sys_clk edge and wins over its own clock edge
  - both clocks rising together store the chain as it was before the shift

 Cascading:
  - serial_out of one block feeds serial_in of the next
  - the clocks and clears are shared along the chain
  - a chain of k blocks holds eight times k bits

 Reset:
  - clears the chain, the storage register and both clock histories
  - the first clock edge is accepted in the cycle after release

 Limitations:
  - a clock pulse shorter than one sys_clk cycle may go unseen
  - back to back pulses need at least two sys_clk cycles each
  - a pin held high through reset counts as an edge at release

 Assumptions about the surroundings:
  - every host pin is synchronous to sys_clk
  - reset is synchronous and active high; one edge clears everything
  - the package and the params header are compiled before this file
*/
`timescale 1ns/10ps
`default_nettype none
`include "sipo_shifter_params.svh"

module sipo_shifter #(
    parameter int WIDTH = `SIPO_WIDTH
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire sipo_shifter_pkg::host_pins_t pins,
    output logic [WIDTH-1:0]                  parallel_out,
    output logic                              serial_out
);

    // stage positions within the shift chain
    localparam int FIRST_STAGE = `SIPO_FIRST_STAGE;
    localparam int LAST_STAGE  = WIDTH - 1;

    // host pins, split out by purpose
    logic             data_pin;
    logic             shift_clock_pin;
    logic             storage_clock_pin;
    logic             shift_clear_active;
    logic             storage_clear_active;

    // clock pin levels seen at the previous sys_clk edge
    logic             shift_clock_d;
    logic             storage_clock_d;

    // detected rising edges, one sys_clk cycle wide
    logic             shift_edge;
    logic             storage_edge;

    // shift chain and the value it takes on a shift
    logic [WIDTH-1:0] shift_stage;
    logic [WIDTH-1:0] shifted;

    // storage register controls
    logic [WIDTH-1:0] store_source;
    logic             store_clear;
    logic             store_load;

    // rising edge: low at the previous sample, high now
    function automatic logic rose_seen(
        input logic now_level,
        input logic last_level
    );
        return now_level & ~last_level;
    endfunction

    // new bit enters stage 0, every other stage takes the one below
    function automatic logic [WIDTH-1:0] shift_once(
        input logic [WIDTH-1:0] stages,
        input logic             new_bit
    );
        logic [WIDTH-1:0] moved;
        moved[FIRST_STAGE] = new_bit;
        for (int n = FIRST_STAGE + 1; n < WIDTH; n++) begin
            moved[n] = stages[n-1];
        end
        return moved;
    endfunction

    // zeros while the shift clear holds, else the chain as it stands
    function automatic logic [WIDTH-1:0] store_pick(
        input logic             clear_active,
        input logic [WIDTH-1:0] stages
    );
        logic [WIDTH-1:0] picked;
        picked = stages;
        if (clear_active) begin
            picked = '0;
        end
        return picked;
    endfunction

    // split the carrier into single pins
    assign data_pin             = pins.serial_in;
    assign shift_clock_pin      = pins.shift_clock;
    assign storage_clock_pin    = pins.storage_clock;
    assign shift_clear_active   = ~pins.shift_clear_n;
    assign storage_clear_active = ~pins.storage_clear_n;

    // reset level matches the idle low pin, so no false edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shift_clock_d <= `SIPO_CLOCK_IDLE;
        end else begin
            shift_clock_d <= shift_clock_pin;
        end
    end

    // storage clock history, same scheme
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            storage_clock_d <= `SIPO_CLOCK_IDLE;
        end else begin
            storage_clock_d <= storage_clock_pin;
        end
    end

    // one-cycle strobes from the two clock pins
    assign shift_edge   = rose_seen(shift_clock_pin, shift_clock_d);
    assign storage_edge = rose_seen(storage_clock_pin, storage_clock_d);

    assign shifted = shift_once(shift_stage, data_pin);

    // clear wins over a shift edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shift_stage <= '0;
        end else begin
            unique case ({shift_clear_active, shift_edge})
                2'h0: begin
                    shift_stage <= shift_stage;
                end
                2'h1: begin
                    shift_stage <= shifted;
                end
                2'h2, 2'h3: begin
                    shift_stage <= '0;
                end
            endcase
        end
    end

    // already zero under shift clear
    assign serial_out = shift_stage[LAST_STAGE];

    // pre-shift contents, so a shared clock stores one pulse behind
    assign store_source = store_pick(shift_clear_active, shift_stage);

    // clear wins over a storage edge
    always_comb begin
        store_clear = 1'h0;
        store_load  = 1'h0;
        unique case ({storage_clear_active, storage_edge})
            2'h0: begin
                store_clear = 1'h0;
                store_load  = 1'h0;
            end
            2'h1: begin
                store_load  = 1'h1;
            end
            2'h2, 2'h3: begin
                store_clear = 1'h1;
            end
        endcase
    end

    // storage register drives the parallel outputs
    storage_register #(
        .WIDTH (WIDTH)
    ) u_storage (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clear     (store_clear),
        .load      (store_load),
        .load_data (store_source),
        .data      (parallel_out)
    );
endmodule

`default_nettype wire

// >>> hdl/sipo_shifter_params.svh
/*
 Constants for the serial-in parallel-out shifter: widths, stage indices
 and clear values. Assumes inclusion by bare name from design files.
*/
`ifndef SIPO_SHIFTER_PARAMS_SVH
`define SIPO_SHIFTER_PARAMS_SVH

`define SIPO_WIDTH        8
`define SIPO_LAST_STAGE   7
`define SIPO_FIRST_STAGE  0
`define SIPO_CLEAR_VALUE  8'h00
`define SIPO_CLOCK_IDLE   1'h0

`endif

// >>> hdl/sipo_shifter_pkg.sv
/*
 Types for the serial-in parallel-out shifter.
 Assumes the params header is compiled alongside.
*/
`include "sipo_shifter_params.svh"

package sipo_shifter_pkg;
    typedef logic [`SIPO_WIDTH-1:0] byte_word_t;

    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic storage_clock;
        logic shift_clear_n;
        logic storage_clear_n;
    } host_pins_t;
endpackage

// >>> hdl/storage_register.sv
/*
 Storage register: loads the shift contents on a load strobe, clears while
 the clear is high. Read data come straight from the register.
 Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sipo_shifter_params.svh"

module storage_register #(
    parameter int WIDTH = `SIPO_WIDTH
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_data,
    output logic      [WIDTH-1:0] data
);
    always_ff @(posedge sys_clk) begin
        if (reset || clear) begin
            data <= '0;
        end else if (load) begin
            data <= load_data;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/host_model.sv
/* host-side model driving the shifter pins; assumes the bench calls step */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic                         sys_clk,
    output var  sipo_shifter_pkg::host_pins_t pins
);
    // clocks low, both clears inactive
    initial pins = 5'h03;
    // drives v for one cycle, then clocks low with the data line inverted
    task automatic step(input logic [4:0] v);
        @(posedge sys_clk) pins <= v;
        @(posedge sys_clk) pins <= {~v[4], 2'h0, v[1:0]};
    endtask
endmodule
`default_nettype wire

// >>> testbench/sipo_shifter_props.sv
/* port checker for the shifter; assumes host pins synchronous to sys_clk */
`timescale 1ns/10ps
`default_nettype none
module sipo_props #(parameter int WIDTH = 8) (
    input wire logic                         sys_clk,
    input wire logic                         reset,
    input wire sipo_shifter_pkg::host_pins_t pins,
    input wire logic [WIDTH-1:0]             parallel_out,
    input wire logic                         serial_out
);
    wire a = pins.shift_clear_n;
    wire b = pins.storage_clear_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_sclr_out: assert property (!a |=> !serial_out) else $error("sclr");
    a_tclr_par: assert property (!b |=> parallel_out == '0) else $error("tclr");
    a_clr_prio: assert property ($rose(pins.storage_clock) && !b |-> ##1 parallel_out == '0)
        else $error("prio");
    a_idle_sout: assert property (a && !$rose(pins.shift_clock) |=> $stable(serial_out))
        else $error("sout");
    a_idle_par: assert property (b && !$rose(pins.storage_clock) |=> $stable(parallel_out))
        else $error("pout");
    a_empty_store: assert property ($rose(pins.storage_clock) && b && !a && !$past(a)
        |=> parallel_out == '0) else $error("empty");
    a_store_msb: assert property ($rose(pins.storage_clock) && a && b
        |=> parallel_out[WIDTH-1] == $past(serial_out)) else $error("msb");
    a_joint_lag: assert property ($rose(pins.shift_clock) && $rose(pins.storage_clock) && a && b
        |=> serial_out == parallel_out[WIDTH-2]) else $error("lag");
    cover property ($rose(pins.shift_clock) && $rose(pins.storage_clock));
    cover property ($rose(pins.storage_clock) && !a);
    cover property (!b);
    cover property ($rose(pins.storage_clock) && !b);
endmodule
bind sipo_shifter sipo_props #(.WIDTH(WIDTH)) i_sipo_props (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .pins         (pins),
    .parallel_out (parallel_out),
    .serial_out   (serial_out)
);
`default_nettype wire

// >>> testbench/tb_top.sv
/* shifter bench with scenario tasks; assumes host model and bound checker */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                         sys_clk = 1'b0;
    logic                         reset = 1'b1;
    logic                         serial_out;
    logic [7:0]                   parallel_out;
    sipo_shifter_pkg::host_pins_t pins;
    int                           fail_count = 0;
    int                           n_checks = 0;
    always #50 sys_clk = ~sys_clk;
    host_model i_host_model (.sys_clk(sys_clk), .pins(pins));
    sipo_shifter #(.WIDTH(8)) i_sipo_shifter (.sys_clk(sys_clk), .reset(reset), .pins(pins),
        .parallel_out(parallel_out), .serial_out(serial_out));
    task automatic go(input logic [4:0] v, input logic [8:0] e);
        i_host_model.step(v);
        #1 n_checks++;
        if ({serial_out, parallel_out} !== e) begin
            fail_count++;
            $display("MISMATCH outputs exp %h got %h", e, {serial_out, parallel_out});
        end
    endtask
    task automatic t_load;
        for (int i = 7; i >= 0; i--) go({i[0], 4'hB}, {i == 0, 8'h00});
        go(5'h07, 9'h1AA);
        $display("t_load done");
    endtask
    task automatic t_clear;
        go(5'h1F, 9'h0AA);
        go(5'h1F, 9'h155);
        go(5'h02, 9'h100);
        go(5'h07, 9'h1AB);
        go(5'h01, 9'h0AB);
        go(5'h0D, 9'h000);
        $display("t_clear done");
    endtask
    task automatic t_prio;
        go(5'h1B, 9'h000);
        go(5'h07, 9'h001);
        go(5'h06, 9'h000);
        go(5'h07, 9'h001);
        go(5'h05, 9'h000);
        $display("t_prio done");
    endtask
    task automatic final_report(input int t);
        fail_count += t;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        t_load();
        t_clear();
        t_prio();
        final_report(0);
    end
    initial #100000 final_report(1);
endmodule
`default_nettype wire
